// ===== rtl/eprpvl_regs.vh
// constants and behaviour overview for the program and verify port
// Overview of operation
// - three arrays: code 16 or 32 KB, 64-byte encryption, 4-byte signature.
// - encryption bytes start as all ones, so verify returns plain code.
// - six low address bits pick the encryption byte during verify.
// - verify byte is code XNOR encryption byte.
// - level 1: no locks; verify encrypted; external table reads see plain code.
// - level 2: external table reads blocked; external-access latched at reset.
// - four factory signature bytes, readable, never changed by programming.
// - program modes need reset high, store-enable low, high supply; pins pick mode.
// - read modes need reset high, store-enable low, strobe and external-access high, supply low.
// - address from port 1, port 2 bits 0-5, top address pin.
// - data on port 0: in when programming, out when reading.
// - one strobe pulse writes one byte.
// - port 0 driven only while the data output enable pin is high.
`ifndef EPRPVL_REGS_VH
`define EPRPVL_REGS_VH
`define EPRPVL_ADDR_W    15
`define EPRPVL_CODE_BIG   32768
`define EPRPVL_CODE_SMALL 16384
`define EPRPVL_LOCK_N    3
`define EPRPVL_ENC_W     6
`define EPRPVL_ENC_DEPTH 64
`define EPRPVL_SIG_DEPTH 4
`define EPRPVL_ERASED    8'hFF
`define EPRPVL_MODE_CODE 5'h0F
`define EPRPVL_MODE_ENC  5'h0D
`define EPRPVL_MODE_LB1  5'h1F
`define EPRPVL_MODE_LB2  5'h1C
`define EPRPVL_MODE_LB3  5'h16
`define EPRPVL_RD_VERIFY 4'h3
`define EPRPVL_RD_SIG    4'h0
`endif

// ===== rtl/eprpvl_core.v
// program, verify and lock logic of the one-time code memory
`timescale 1ns/1ps
`include "eprpvl_regs.vh"
module eprpvl_core #(
  parameter        BIG_VARIANT = 1,
  parameter [31:0] SIG_WORD    = 32'h5A5A_A5A5
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        resetPin,
  input  wire        programStoreEnableN,
  input  wire        addrLatchProgramStrobe,
  input  wire        externalAccessPin,
  input  wire        progSupplyHigh,
  input  wire        modeSelectA,
  input  wire        dataOutputEnablePin,
  input  wire        modeSelectB,
  input  wire        modeSelectC,
  input  wire        modeSelectD,
  input  wire [7:0]  port1In,
  input  wire [5:0]  port2LowIn,
  input  wire        topAddressPin,
  input  wire [7:0]  port0In,
  input  wire        cpuReadReq,
  input  wire        cpuFromExternal,
  input  wire [14:0] cpuAddr,
  output reg  [7:0]  port0Out,
  output reg         port0Oe,
  output reg  [7:0]  cpuData,
  output reg         cpuBlocked,
  output reg  [2:0]  lockBits,
  output reg         eaLatched
);
  // code depth follows the variant; the small part drops A14
  localparam CODE_DEPTH = BIG_VARIANT ? `EPRPVL_CODE_BIG : `EPRPVL_CODE_SMALL;
  localparam CODE_LAST  = `EPRPVL_CODE_BIG - 1;
  localparam ENC_LAST   = `EPRPVL_ENC_DEPTH - 1;
  localparam SIG_LAST   = `EPRPVL_SIG_DEPTH - 1;

  // program strobe tracker, one-hot
  localparam [1:0] STB_HIGH = 2'h1;
  localparam [1:0] STB_LOW  = 2'h2;

  // nonvolatile arrays; rstn leaves them alone
  reg  [7:0]  codeMem [0:CODE_LAST];
  reg  [7:0]  encMem  [0:ENC_LAST];
  wire [7:0]  sigByte [0:SIG_LAST];

  // state and next values
  reg  [1:0]  stbState_q;
  reg  [1:0]  stbState_d;
  reg         resetPin_q;
  reg  [2:0]  lockBits_d;
  reg         eaLatched_d;
  reg  [7:0]  port0Out_d;
  reg         port0Oe_d;
  reg  [7:0]  cpuData_d;
  reg         cpuBlocked_d;

  // decoded pins and qualifiers
  wire        topBit;
  wire [14:0] addr;
  wire [5:0]  encIdx;
  wire [1:0]  sigIdx;
  wire [4:0]  progSel;
  wire [3:0]  rdSel;
  wire        setupOk;
  wire        progOk;
  wire        readOk;
  wire        isCode;
  wire        isEnc;
  wire        isLb1;
  wire        isLb2;
  wire        isLb3;
  wire        isVerify;
  wire        isSig;
  wire        strobeFall;
  wire        doWrite;
  wire        inCode;
  wire        wrCode;
  wire        wrEnc;
  wire [7:0]  codeByte;
  wire [7:0]  encByte;
  wire [7:0]  verifyByte;
  wire        cpuDeny;
  wire        readDrive;
  wire [2:0]  lockSel;
  wire [2:0]  lockSet;
  integer     i;
  genvar      g;

  // factory signature bytes, low byte at index 0
  generate
    for (g = 0; g < `EPRPVL_SIG_DEPTH; g = g + 1) begin : gSig
      assign sigByte[g] = SIG_WORD[8*g +: 8];
    end
  endgenerate

  // address assembly; the small variant never sees A14
  assign topBit     = (BIG_VARIANT != 0) & topAddressPin;
  assign addr       = {topBit, port2LowIn, port1In};
  assign encIdx     = addr[5:0];
  assign sigIdx     = addr[1:0];

  // mode pin groups
  assign progSel    = {modeSelectA, dataOutputEnablePin, modeSelectB, modeSelectC, modeSelectD};
  assign rdSel      = {modeSelectA, modeSelectB, modeSelectC, modeSelectD};

  // set-up qualification
  assign setupOk    = resetPin & ~programStoreEnableN;
  assign progOk     = setupOk & progSupplyHigh;
  assign readOk     = setupOk & ~progSupplyHigh & addrLatchProgramStrobe & externalAccessPin;

  // mode decode
  assign isCode     = (progSel == `EPRPVL_MODE_CODE);
  assign isEnc      = (progSel == `EPRPVL_MODE_ENC);
  assign isLb1      = (progSel == `EPRPVL_MODE_LB1);
  assign isLb2      = (progSel == `EPRPVL_MODE_LB2);
  assign isLb3      = (progSel == `EPRPVL_MODE_LB3);
  assign isVerify   = (rdSel == `EPRPVL_RD_VERIFY);
  assign isSig      = (rdSel == `EPRPVL_RD_SIG);

  // one write per falling strobe edge, however long the pulse
  assign strobeFall = stbState_q[0] & ~addrLatchProgramStrobe;
  assign doWrite    = progOk & strobeFall;
  assign inCode     = ({17'h00000, addr} < CODE_DEPTH);
  assign wrCode     = doWrite & isCode & inCode;
  assign wrEnc      = doWrite & isEnc;

  // verify path
  assign codeByte   = codeMem[addr];
  assign encByte    = encMem[encIdx];
  assign verifyByte = ~(codeByte ^ encByte);
  assign readDrive  = readOk & dataOutputEnablePin & (isVerify | isSig);

  // table reads from external code lose access at level 2
  assign cpuDeny    = cpuFromExternal & lockBits[0];

  // lock bit set requests, one per bit
  assign lockSel    = {isLb3, isLb2, isLb1};
  generate
    for (g = 0; g < `EPRPVL_LOCK_N; g = g + 1) begin : gLock
      assign lockSet[g] = doWrite & lockSel[g];
    end
  endgenerate

  // code and encryption arrays power up erased
  initial begin
    for (i = 0; i <= CODE_LAST; i = i + 1)
      codeMem[i] = `EPRPVL_ERASED;
    for (i = 0; i <= ENC_LAST; i = i + 1)
      encMem[i] = `EPRPVL_ERASED;
  end

  // code array write port
  always @(posedge core_clk) begin
    if (wrCode)
      codeMem[addr] <= port0In;
  end

  // encryption array write port
  always @(posedge core_clk) begin
    if (wrEnc)
      encMem[encIdx] <= port0In;
  end

  // strobe tracker next state
  always @* begin
    stbState_d = stbState_q;
    case (stbState_q)
      STB_HIGH: begin
        if (!addrLatchProgramStrobe)
          stbState_d = STB_LOW;
      end
      STB_LOW: begin
        if (addrLatchProgramStrobe)
          stbState_d = STB_HIGH;
      end
      default: begin
        stbState_d = STB_HIGH;
      end
    endcase
  end

  // lock bits only ever gain ones
  always @* begin
    lockBits_d = lockBits | lockSet;
  end

  // external-access level caught as the reset pin falls
  always @* begin
    eaLatched_d = eaLatched;
    if (resetPin_q && !resetPin)
      eaLatched_d = externalAccessPin;
  end

  // data port drive
  always @* begin
    port0Oe_d = readDrive;
    if (isSig)
      port0Out_d = sigByte[sigIdx];
    else
      port0Out_d = verifyByte;
  end

  // table read answer, held until the next request
  always @* begin
    cpuData_d    = cpuData;
    cpuBlocked_d = cpuBlocked;
    if (cpuReadReq) begin
      cpuBlocked_d = cpuDeny;
      if (cpuDeny)
        cpuData_d = 8'h00;
      else
        cpuData_d = codeMem[cpuAddr];
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stbState_q <= STB_HIGH;
    end else begin
      stbState_q <= stbState_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resetPin_q <= 1'b0;
    end else begin
      resetPin_q <= resetPin;
    end
  end

  // rstn stands for power-on here, the only way back to unlocked
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lockBits <= 3'h0;
    end else begin
      lockBits <= lockBits_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      eaLatched <= 1'b0;
    end else begin
      eaLatched <= eaLatched_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port0Oe <= 1'b0;
    end else begin
      port0Oe <= port0Oe_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port0Out <= 8'h00;
    end else begin
      port0Out <= port0Out_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpuData <= 8'h00;
    end else begin
      cpuData <= cpuData_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpuBlocked <= 1'b0;
    end else begin
      cpuBlocked <= cpuBlocked_d;
    end
  end

endmodule

// ===== dv/eprpvl_sva_asserts.sv
// assertions for the program, verify and lock port
`timescale 1ns/1ps
module eprpvl_sva (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       addrLatchProgramStrobe,
  input wire logic       progSupplyHigh,
  input wire logic       dataOutputEnablePin,
  input wire logic       cpuReadReq,
  input wire logic       cpuFromExternal,
  input wire logic       port0Oe,
  input wire logic       cpuBlocked,
  input wire logic [7:0] cpuData,
  input wire logic [2:0] lockBits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence noStrobe; addrLatchProgramStrobe || !progSupplyHigh; endsequence
  chk_oe_gate: assert property (port0Oe |-> $past(dataOutputEnablePin)) else $error("oe gate");
  chk_oe_supply: assert property (port0Oe |-> !$past(progSupplyHigh)) else $error("oe supply");
  chk_oe_strobe: assert property (port0Oe |-> $past(addrLatchProgramStrobe)) else $error("oe strobe");
  chk_lock_stay: assert property ((lockBits & $past(lockBits)) == $past(lockBits)) else $error("lock lost");
  chk_lock_cause: assert property (not (noStrobe ##1 $rose(lockBits[0]))) else $error("lock cause");
  chk_ext_block: assert property (cpuReadReq && cpuFromExternal && lockBits[0] |=> cpuBlocked && cpuData == 8'h00)
    else $error("not blocked");
  chk_level_one: assert property (cpuReadReq && lockBits == 3'h0 |=> !cpuBlocked) else $error("blocked");
  chk_cpu_hold: assert property (!cpuReadReq |=> $stable(cpuData)) else $error("cpu data moved");
endmodule
bind eprpvl_core eprpvl_sva i_eprpvl_sva (.*);

// ===== dv/eprpvl_pgm.sv
// programmer model driving the set-up pins
`timescale 1ns/1ps
module eprpvl_pgm (
  input wire logic    core_clk,
  output logic        addrLatchProgramStrobe = 1'b1, progSupplyHigh = 1'b0, modeSelectA, dataOutputEnablePin,
  output logic        modeSelectB, modeSelectC, modeSelectD, topAddressPin,
  output logic [7:0]  port1In, port0In,
  output logic [5:0]  port2LowIn
);
  task step; @(posedge core_clk); #1; endtask
  task put(input [4:0] m, input [14:0] a, input [7:0] d);
    {modeSelectA, dataOutputEnablePin, modeSelectB, modeSelectC, modeSelectD} = m;
    {topAddressPin, port2LowIn, port1In} = a;
    port0In = d;
  endtask
  initial put(5'h00, 15'h0000, 8'h00);
  task prog(input [4:0] m, input [14:0] a, input [7:0] d);
    put(m, a, d); step; progSupplyHigh = 1'b1; step; addrLatchProgramStrobe = 1'b0; step;
    addrLatchProgramStrobe = 1'b1; step; progSupplyHigh = 1'b0;
  endtask
  // released data lines show the inverse of the last value
  task read(input [4:0] m, input [14:0] a); put(m, a, ~port0In); step; step; endtask
endmodule

// ===== dv/eprpvl_core_tb.sv
// bench for the program, verify and lock port
`timescale 1ns/1ps
`include "eprpvl_regs.vh"
module eprpvl_core_tb;
  logic core_clk = 1'b0, rstn = 1'b0, cpuReadReq = 1'b0, resetPin = 1'b1, cpuFromExternal = 1'b1;
  logic externalAccessPin = 1'b1, programStoreEnableN = 1'b0, addrLatchProgramStrobe, progSupplyHigh;
  logic modeSelectA, dataOutputEnablePin, modeSelectB, modeSelectC, modeSelectD, topAddressPin;
  logic port0Oe, cpuBlocked, eaLatched;
  logic [14:0] cpuAddr = 15'h4005;
  logic [7:0]  port1In, port0In, port0Out, cpuData;
  logic [5:0]  port2LowIn;
  logic [2:0]  lockBits;
  logic [30:0] rows [2] = '{{15'h4005, 8'hA5, 8'hA5}, {15'h3FFF, 8'h00, 8'h00}};
  int          fail_count = 0, comparisons = 0;
  eprpvl_pgm  i_eprpvl_pgm (.*);
  // signature word value is arbitrary
  eprpvl_core #(.SIG_WORD(32'h1234_5678)) i_eprpvl_core (.*);
  always #2.5 core_clk = ~core_clk;
  task chk(input string what, input [7:0] exp, input [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tableRead(input [7:0] exp, input blk);
    cpuReadReq = 1'b1;
    i_eprpvl_pgm.step;
    cpuReadReq = 1'b0;
    chk("table", exp, cpuData);
    chk("blocked", {7'h00, blk}, {7'h00, cpuBlocked});
  endtask
  initial begin
    #9000 fail_count++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
    foreach (rows[i]) begin
      i_eprpvl_pgm.prog(`EPRPVL_MODE_CODE, rows[i][30:16], rows[i][15:8]);
      i_eprpvl_pgm.read(5'h0B, rows[i][30:16]);
      chk("verify", rows[i][7:0], port0Out);
    end
    tableRead(8'hA5, 1'b0);
    i_eprpvl_pgm.prog(`EPRPVL_MODE_ENC, 15'h7FC5, 8'h0F);
    i_eprpvl_pgm.read(5'h0B, 15'h4005);
    chk("xnor", 8'h55, port0Out);
    i_eprpvl_pgm.read(5'h03, 15'h4005);
    chk("oe", 8'h00, {7'h00, port0Oe});
    i_eprpvl_pgm.read(5'h08, 15'h0001);
    chk("sig", 8'h56, port0Out);
    chk("sig oe", 8'h01, {7'h00, port0Oe});
    resetPin = 1'b0;
    i_eprpvl_pgm.step;
    chk("ea", 8'h01, {7'h00, eaLatched});
    resetPin = 1'b1;
    i_eprpvl_pgm.step;
    i_eprpvl_pgm.prog(`EPRPVL_MODE_LB1, 15'h0000, 8'h00);
    chk("lock", 8'h01, {5'h00, lockBits});
    tableRead(8'h00, 1'b1);
    i_eprpvl_pgm.prog(`EPRPVL_MODE_LB2, 15'h0000, 8'h00);
    i_eprpvl_pgm.prog(`EPRPVL_MODE_LB3, 15'h0000, 8'h00);
    chk("lock all", 8'h07, {5'h00, lockBits});
    give_verdict;
  end
endmodule
